/* logic/tap_programmer.sv */
// Summary of operation
// [RULE_01] accept a frame only when address bits five to two equal the select pins
// [RULE_02] address top bit must be zero; two lowest address bits are ignored
// [RULE_03] only write transfers exist; reads are never answered with data
// [RULE_04] frame: start, address, write bit, ack, one data byte, nack, stop
// [RULE_05] data byte: upper three bits pick channel, lower five bits give tap
// [RULE_06] channels 0..3 are signal channels, 4 the reference clock; independent registers
// [RULE_07] tap 0..24 selects that delay stage out of 25, one step apart
// [RULE_08] tap 25 forces output low, tap 27 forces output high
// [RULE_09] tap 26 routes the phase detector output for test
// [RULE_10] each channel keeps a five-bit register steering its 25:1 selector
// [RULE_11] reference channel selects a stage of its own line as deskewed clock
// [RULE_12] each delayed output is its signal input through its selected source
// [RULE_13] first serial clock falling edge starts the internal reset sequence
// [RULE_14] the first transfer after power-up leaves all tap registers unchanged
// [RULE_15] the reference clock must keep running during the reset sequence
// [RULE_16] controller should send one arbitrary transfer right after power-up
// [RULE_17] reference clock is nominally 40 MHz so one step equals one nanosecond; here a step is one 8 ns mclk cycle
// [RULE_18] channel select 5, 6 or 7 leaves every register unchanged
// [RULE_19] tap values 28..31 behave as constant low
// [RULE_20] commit only after all eight data bits; data line released otherwise
`default_nettype none
module tap_programmer (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       scl_clk,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_drive_n,
  input  wire logic [3:0] address_select_pins,
  input  wire logic       reference_clock_in,
  input  wire logic       phase_detect_in,
  input  wire logic [3:0] signal_inputs,
  output var  logic [3:0] delayed_outputs,
  output var  logic       deskewed_clock_out
);

  // address hit test; low bits deliberately not looked at
  function automatic logic addr_hit(input delay_prog_pkg::addr_byte_t a, input logic [3:0] pins);
    addr_hit = (a.top == delay_prog_pkg::ADDR_TOP_REQUIRED) && (a.select == pins) &&
               (a.dir == delay_prog_pkg::DIR_WRITE);
  endfunction

  // undefined codes folded onto constant low
  function automatic logic [4:0] tap_fold(input logic [4:0] t);
    tap_fold = (t > delay_prog_pkg::TAP_CONST_HIGH) ? delay_prog_pkg::TAP_CONST_LOW : t;
  endfunction

  logic [7:0]                     shift_q;
  logic                           scl_meta_q;
  logic                           scl_sync_q;
  logic                           scl_prev_q;
  logic                           sda_meta_q;
  logic                           sda_sync_q;
  logic                           sda_prev_q;
  logic [3:0]                     pins_meta_q;
  logic [3:0]                     pins_sync_q;
  logic [5:0]                     in_meta_q;
  logic [5:0]                     in_sync_q;
  logic                           scl_rise;
  logic                           scl_fall;
  logic                           start_cond;
  logic                           stop_cond;
  delay_prog_pkg::link_state_t    state_q;
  logic [3:0]                     bit_cnt_q;
  logic                           byte_done;
  logic                           armed_q;
  logic                           seq_active_q;
  logic [4:0]                     seq_cnt_q;
  logic                           skip_q;
  logic                           sda_drive_q;
  delay_prog_pkg::addr_byte_t     addr_byte;
  delay_prog_pkg::prog_byte_t     data_byte;
  logic                           addr_accept;
  logic                           chan_ok;
  logic                           commit_fire;
  logic [2:0]                     commit_chan;
  logic [4:0]                     commit_val;
  logic [4:0]                     taps_q [delay_prog_pkg::NUM_CHAN];
  logic [24:0]                    taps_flat;
  logic [delay_prog_pkg::NUM_CHAN-1:0] line_out;

  // link domain: bits shift in on the rising serial clock; data only, no reset needed
  always_ff @(posedge scl_clk) begin
    shift_q <= {shift_q[6:0], sda_in};
  end

  // serial lines into mclk, two stages then an edge-detect stage
  always_ff @(posedge mclk) begin
    if (srst) begin
      scl_meta_q <= 1'b1;
      scl_sync_q <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_meta_q <= 1'b1;
      sda_sync_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_meta_q <= scl_clk;
      scl_sync_q <= scl_meta_q;
      scl_prev_q <= scl_sync_q;
      sda_meta_q <= sda_in;
      sda_sync_q <= sda_meta_q;
      sda_prev_q <= sda_sync_q;
    end
  end

  // pins and signal inputs pass two stages before anything reads them
  always_ff @(posedge mclk) begin
    if (srst) begin
      pins_meta_q <= 4'h0;
      pins_sync_q <= 4'h0;
      in_meta_q   <= 6'h00;
      in_sync_q   <= 6'h00;
    end else begin
      pins_meta_q <= address_select_pins;
      pins_sync_q <= pins_meta_q;
      in_meta_q   <= {phase_detect_in, reference_clock_in, signal_inputs};
      in_sync_q   <= in_meta_q;
    end
  end

  // bus events seen in the mclk domain
  assign scl_rise   = scl_sync_q & ~scl_prev_q;
  assign scl_fall   = ~scl_sync_q & scl_prev_q;
  assign start_cond = scl_sync_q & scl_prev_q & sda_prev_q & ~sda_sync_q;
  assign stop_cond  = scl_sync_q & scl_prev_q & ~sda_prev_q & sda_sync_q;
  assign byte_done  = scl_fall && (bit_cnt_q == delay_prog_pkg::BITS_PER_BYTE);

  // shift_q is read only after a synced falling edge, while scl is low and the
  // register cannot move; the serial clock itself acts as the handshake
  assign addr_byte   = delay_prog_pkg::addr_byte_t'(shift_q);
  assign data_byte   = delay_prog_pkg::prog_byte_t'(shift_q);
  assign addr_accept = (state_q == delay_prog_pkg::ST_ADDR) && byte_done &&
                       addr_hit(addr_byte, pins_sync_q) && !skip_q; // RULE_01 RULE_02 RULE_03
  assign chan_ok     = data_byte.chan <= delay_prog_pkg::CHAN_REFCLK; // RULE_18
  assign commit_fire = (state_q == delay_prog_pkg::ST_DATA) && byte_done && chan_ok &&
                       !skip_q && !seq_active_q; // RULE_20 RULE_14
  assign commit_chan = data_byte.chan; // RULE_05
  assign commit_val  = tap_fold(data_byte.tap); // RULE_05 RULE_19

  // internal reset sequence, started by the first falling serial clock edge;
  // it counts mclk, so the reference clock must stay alive meanwhile
  always_ff @(posedge mclk) begin
    if (srst) begin
      armed_q      <= 1'b0;
      seq_active_q <= 1'b0;
      seq_cnt_q    <= 5'h00;
    end else if (!armed_q && scl_fall) begin
      armed_q      <= 1'b1; // RULE_13
      seq_active_q <= 1'b1;
      seq_cnt_q    <= 5'h00;
    end else if (seq_active_q) begin
      seq_cnt_q    <= seq_cnt_q + 5'h01;
      seq_active_q <= (seq_cnt_q != delay_prog_pkg::RESET_SEQ_LAST);
    end
  end

  // first frame is swallowed by the reset; skip lasts to its stop
  always_ff @(posedge mclk) begin
    if (srst) begin
      skip_q <= 1'b0;
    end else if (!armed_q && scl_fall) begin
      skip_q <= 1'b1; // RULE_14
    end else if (stop_cond) begin
      skip_q <= 1'b0;
    end
  end

  // frame sequencer; start and stop override any state
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= delay_prog_pkg::ST_IDLE;
    end else if (start_cond) begin
      state_q <= delay_prog_pkg::ST_ADDR; // RULE_04
    end else if (stop_cond) begin
      state_q <= delay_prog_pkg::ST_IDLE;
    end else begin
      case (state_q)
        delay_prog_pkg::ST_ADDR: begin
          if (byte_done) begin
            state_q <= addr_accept ? delay_prog_pkg::ST_ACK : delay_prog_pkg::ST_WAIT_STOP; // RULE_01
          end
        end
        delay_prog_pkg::ST_ACK: begin
          if (scl_fall) begin
            state_q <= delay_prog_pkg::ST_DATA; // RULE_04
          end
        end
        delay_prog_pkg::ST_DATA: begin
          if (byte_done) begin
            state_q <= delay_prog_pkg::ST_NACK; // RULE_04
          end
        end
        delay_prog_pkg::ST_NACK: begin
          if (scl_fall) begin
            state_q <= delay_prog_pkg::ST_WAIT_STOP; // RULE_04
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // rising edges counted per byte; stops at eight until the ack slot ends or the next start
  always_ff @(posedge mclk) begin
    if (srst || start_cond) begin
      bit_cnt_q <= 4'h0;
    end else if (state_q == delay_prog_pkg::ST_ACK && scl_fall) begin
      bit_cnt_q <= 4'h0;
    end else if ((state_q == delay_prog_pkg::ST_ADDR || state_q == delay_prog_pkg::ST_DATA) &&
                 scl_rise && bit_cnt_q != delay_prog_pkg::BITS_PER_BYTE) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // acknowledge pull-down only for the ack slot; the nack slot stays released
  always_ff @(posedge mclk) begin
    if (srst || start_cond || stop_cond) begin
      sda_drive_q <= 1'b0;
    end else if (addr_accept) begin
      sda_drive_q <= 1'b1; // RULE_04
    end else if (state_q == delay_prog_pkg::ST_ACK && scl_fall) begin
      sda_drive_q <= 1'b0; // RULE_20
    end
  end

  // open drain: the pad only ever pulls low
  assign sda_out     = 1'b0;
  assign sda_drive_n = ~sda_drive_q;

  // tap registers; reset and the reset sequence load TAP_RESET into all, otherwise only a full, valid data byte writes one of them
  always_ff @(posedge mclk) begin
    if (srst || seq_active_q) begin
      for (int c = 0; c < delay_prog_pkg::NUM_CHAN; c++) begin
        taps_q[c] <= delay_prog_pkg::TAP_RESET;
      end
    end else if (commit_fire) begin
      taps_q[commit_chan] <= commit_val; // RULE_06 RULE_10
    end
  end

  assign taps_flat = {taps_q[4], taps_q[3], taps_q[2], taps_q[1], taps_q[0]};

  // one line per channel; the last one carries the reference clock
  for (genvar g = 0; g < delay_prog_pkg::NUM_CHAN; g++) begin : g_line
    tap_line u_line (
      .mclk     (mclk),
      .srst     (srst),
      .din      (in_sync_q[g]), // RULE_11 RULE_12
      .phase_in (in_sync_q[5]),
      .tap      (taps_q[g]), // RULE_10
      .dout     (line_out[g])
    );
  end

  assign delayed_outputs    = line_out[3:0]; // RULE_12
  assign deskewed_clock_out = line_out[4]; // RULE_11

  addr_pins_a: assert property (@(posedge mclk) disable iff (srst)
    state_q == delay_prog_pkg::ST_ADDR && byte_done && !start_cond && !stop_cond &&
    addr_byte.select != pins_sync_q |=> state_q == delay_prog_pkg::ST_WAIT_STOP && !sda_drive_q)
    else $error("address with wrong select bits acknowledged"); // RULE_01
  addr_top_a: assert property (@(posedge mclk) disable iff (srst)
    state_q == delay_prog_pkg::ST_ADDR && byte_done && !start_cond && !stop_cond && addr_byte.top
    |=> state_q == delay_prog_pkg::ST_WAIT_STOP) else $error("address with top bit set accepted"); // RULE_02
  read_refused_a: assert property (@(posedge mclk) disable iff (srst)
    state_q == delay_prog_pkg::ST_ADDR && byte_done && addr_byte.dir |=> !sda_drive_q [*3])
    else $error("read transfer acknowledged"); // RULE_03
  ack_slot_a: assert property (@(posedge mclk) disable iff (srst)
    state_q == delay_prog_pkg::ST_ACK && scl_fall && !start_cond && !stop_cond
    |=> !sda_drive_q && state_q == delay_prog_pkg::ST_DATA) else $error("ack slot not closed"); // RULE_04
  ack_drive_a: assert property (@(posedge mclk) disable iff (srst)
    addr_accept && !start_cond && !stop_cond |=> sda_drive_q && state_q == delay_prog_pkg::ST_ACK)
    else $error("accepted address not acknowledged"); // RULE_04
  commit_value_a: assert property (@(posedge mclk) disable iff (srst)
    commit_fire |=> taps_q[$past(commit_chan)] == $past(commit_val))
    else $error("tap register not written"); // RULE_05
  bad_chan_a: assert property (@(posedge mclk) disable iff (srst)
    state_q == delay_prog_pkg::ST_DATA && byte_done && !chan_ok && !seq_active_q
    |=> taps_flat == $past(taps_flat)) else $error("invalid channel changed a register"); // RULE_18
  fold_low_a: assert property (@(posedge mclk) disable iff (srst)
    commit_fire && data_byte.tap > delay_prog_pkg::TAP_CONST_HIGH
    |=> taps_q[$past(commit_chan)] == delay_prog_pkg::TAP_CONST_LOW)
    else $error("undefined tap not folded to low"); // RULE_19
  reset_seq_a: assert property (@(posedge mclk) disable iff (srst)
    !armed_q && scl_fall |=> seq_active_q && skip_q ##1 taps_flat == {5{delay_prog_pkg::TAP_RESET}})
    else $error("first scl fall did not start reset"); // RULE_13
  first_frame_a: assert property (@(posedge mclk) disable iff (srst)
    skip_q && !seq_active_q |=> taps_flat == $past(taps_flat))
    else $error("first transfer changed a register"); // RULE_14
  partial_byte_a: assert property (@(posedge mclk) disable iff (srst)
    state_q == delay_prog_pkg::ST_DATA && !byte_done && !seq_active_q |=> taps_flat == $past(taps_flat))
    else $error("register written before eight bits"); // RULE_20

  commit_cov: cover property (@(posedge mclk) disable iff (srst) commit_fire);
  refclk_cov: cover property (@(posedge mclk) disable iff (srst)
    commit_fire && commit_chan == delay_prog_pkg::CHAN_REFCLK);
  refuse_cov: cover property (@(posedge mclk) disable iff (srst)
    state_q == delay_prog_pkg::ST_ADDR && byte_done && !addr_accept);
  reset_cov: cover property (@(posedge mclk) disable iff (srst) $rose(seq_active_q));

endmodule
`default_nettype wire

/* logic/delay_prog_pkg.sv */
`default_nettype none
package delay_prog_pkg;

  // channel counts and widths
  localparam int NUM_SIGNAL = 4;
  localparam int NUM_CHAN   = 5;
  localparam int NUM_TAPS   = 25;

  // channel-select encoding
  localparam logic [2:0] CHAN_REFCLK = 3'h4;

  // tap-value encoding
  localparam logic [4:0] TAP_LAST_DELAY = 5'h18;
  localparam logic [4:0] TAP_CONST_LOW  = 5'h19;
  localparam logic [4:0] TAP_PHASE      = 5'h1A;
  localparam logic [4:0] TAP_CONST_HIGH = 5'h1B;
  localparam logic [4:0] TAP_RESET      = 5'h19;

  // frame layout
  localparam logic [3:0] BITS_PER_BYTE     = 4'h8;
  localparam logic       ADDR_TOP_REQUIRED = 1'h0;
  localparam logic       DIR_WRITE         = 1'h0;

  // internal reset sequence length
  localparam int         MCLK_PERIOD_NS    = 8;
  localparam int         RESET_SEQ_NS      = 200;
  localparam int         RESET_SEQ_CYCLES  = (RESET_SEQ_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam logic [4:0] RESET_SEQ_LAST    = 5'(RESET_SEQ_CYCLES - 1);

  // address byte as it arrives, msb first
  typedef struct packed {
    logic       top;
    logic [3:0] select;
    logic [1:0] low;
    logic       dir;
  } addr_byte_t;

  // data byte: channel select over tap value
  typedef struct packed {
    logic [2:0] chan;
    logic [4:0] tap;
  } prog_byte_t;

  typedef enum logic [5:0] {
    ST_IDLE      = 6'h01,
    ST_ADDR      = 6'h02,
    ST_ACK       = 6'h04,
    ST_DATA      = 6'h08,
    ST_NACK      = 6'h10,
    ST_WAIT_STOP = 6'h20
  } link_state_t;

endpackage
`default_nettype wire

/* logic/tap_line.sv */
`default_nettype none
// one delay line: 25 stages on mclk and a registered 25:1 selector
module tap_line (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       din,
  input  wire logic       phase_in,
  input  wire logic [4:0] tap,
  output var  logic       dout
);

  logic [delay_prog_pkg::NUM_TAPS-1:0] line_q;

  // stage chain, one stage per clock stands in for the analog step
  always_ff @(posedge mclk) begin
    if (srst) begin
      line_q <= '0;
    end else begin
      line_q <= {line_q[delay_prog_pkg::NUM_TAPS-2:0], din};
    end
  end

  // output selector
  always_ff @(posedge mclk) begin
    if (srst) begin
      dout <= 1'b0;
    end else if (tap <= delay_prog_pkg::TAP_LAST_DELAY) begin
      dout <= line_q[tap]; // RULE_07
    end else if (tap == delay_prog_pkg::TAP_PHASE) begin
      dout <= phase_in; // RULE_09
    end else if (tap == delay_prog_pkg::TAP_CONST_HIGH) begin
      dout <= 1'b1; // RULE_08
    end else begin
      dout <= 1'b0; // RULE_08
    end
  end

  const_low_a: assert property (@(posedge mclk) disable iff (srst)
    tap == delay_prog_pkg::TAP_CONST_LOW |=> !dout) else $error("constant low tap not low"); // RULE_08
  const_high_a: assert property (@(posedge mclk) disable iff (srst)
    tap == delay_prog_pkg::TAP_CONST_HIGH |=> dout) else $error("constant high tap not high"); // RULE_08
  phase_route_a: assert property (@(posedge mclk) disable iff (srst)
    tap == delay_prog_pkg::TAP_PHASE |=> dout == $past(phase_in)) else $error("phase tap mismatch"); // RULE_09
  tap_zero_a: assert property (@(posedge mclk) disable iff (srst)
    (tap == 5'h00) [*2] |=> dout == $past(din, 2)) else $error("tap zero delay wrong"); // RULE_07

endmodule
`default_nettype wire

/* dv/i2c_controller_model.sv */
`default_nettype none
// two-wire bus controller: open-drain data, clock stands high between frames
module i2c_controller_model (
  output var  logic scl,
  output var  logic sda_low,
  input  wire logic sda_wire
);
  timeunit 1ns;
  timeprecision 100ps;

  // 80 ns link period, 40 ns per scl phase: five mclk each, room for the two-stage sync
  localparam int PHASE_NS = 40;
  logic got;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // data changes mid low phase and is sampled at the rising edge
  task automatic put_bit(input logic b);
    #(PHASE_NS / 2) sda_low = ~b;
    #(PHASE_NS / 2) scl = 1'b1;
    got = sda_wire;
    #(PHASE_NS) scl = 1'b0;
  endtask

  // start, address, direction, ack slot, up to eight data bits, nack slot only after all eight, stop
  task automatic send_frame(input logic [6:0] addr, input logic rd, input logic [7:0] data,
                            input int nbits, output logic addr_ack, output logic data_nack);
    #2;
    sda_low = 1'b1;
    #(PHASE_NS) scl = 1'b0;
    for (int i = 6; i >= 0; i--) begin
      put_bit(addr[i]);
    end
    put_bit(rd);
    put_bit(1'b1);
    addr_ack = ~got;
    data_nack = 1'b1;
    for (int i = 7; i > 7 - nbits; i--) begin
      put_bit(data[i]);
    end
    if (nbits == 8) begin
      put_bit(1'b1);
      data_nack = got;
    end
    // stop: data rises while clock is high, may cut a byte short
    #(PHASE_NS / 2) sda_low = 1'b1;
    #(PHASE_NS / 2) scl = 1'b1;
    #(PHASE_NS) sda_low = 1'b0;
    #(PHASE_NS);
  endtask
endmodule
`default_nettype wire

/* dv/i2c_delay_tap_programmer_tb_top.sv */
`default_nettype none
`define CHECK(name, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("wrong value %s expected %h seen %h", name, exp, got); \
    end \
  end

module i2c_delay_tap_programmer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk;
  logic        srst;
  logic        scl_clk;
  logic        ctrl_low;
  logic        sda_out;
  logic        sda_drive_n;
  logic        sda_wire;
  logic [3:0]  address_select_pins;
  logic        reference_clock_in;
  logic        phase_detect_in;
  logic [3:0]  signal_inputs;
  logic [3:0]  delayed_outputs;
  logic        deskewed_clock_out;
  logic [4:0]  exp_tap [0:4];
  logic [5:0]  hist [0:31];
  logic [31:0] rnd_in;
  logic [31:0] rnd_st;
  logic        first_frame;
  logic        check_on;
  logic        ack;
  logic        nack;
  int          n_mismatch;
  int          total_checks;

  // pull-up on the shared data wire, low when either side pulls
  assign sda_wire = (ctrl_low || (!sda_drive_n && !sda_out)) ? 1'b0 : 1'b1;

  tap_programmer tap_programmer_inst (
    .mclk                (mclk),
    .srst                (srst),
    .scl_clk             (scl_clk),
    .sda_in              (sda_wire),
    .sda_out             (sda_out),
    .sda_drive_n         (sda_drive_n),
    .address_select_pins (address_select_pins),
    .reference_clock_in  (reference_clock_in),
    .phase_detect_in     (phase_detect_in),
    .signal_inputs       (signal_inputs),
    .delayed_outputs     (delayed_outputs),
    .deskewed_clock_out  (deskewed_clock_out)
  );

  i2c_controller_model i2c_controller_model_inst (
    .scl      (scl_clk),
    .sda_low  (ctrl_low),
    .sda_wire (sda_wire)
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected output of a channel from its tap and the input history
  function automatic logic exp_out(input int ch);
    logic [4:0] t;
    t = exp_tap[ch];
    if (t <= delay_prog_pkg::TAP_LAST_DELAY) return hist[t + 4][ch];
    if (t === delay_prog_pkg::TAP_PHASE) return hist[3][5];
    if (t === delay_prog_pkg::TAP_CONST_HIGH) return 1'b1;
    return 1'b0;
  endfunction

  // core clock never stops, it also stands for the reference during reset
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // reference clock of its own, 25 ns period; the offset keeps its edges off mclk edges
  initial begin
    reference_clock_in = 1'b0;
    #0.3;
    forever #12.5 reference_clock_in = ~reference_clock_in;
  end

  // random levels on signal and phase inputs every cycle
  initial begin
    rnd_in = 32'h0000CC44;
    {phase_detect_in, signal_inputs} = 5'h00;
    forever begin
      @(posedge mclk);
      #1;
      rnd_in = lfsr_next(rnd_in);
      {phase_detect_in, signal_inputs} = {rnd_in[5], rnd_in[3:0]};
    end
  end

  // input history and output comparison while taps are settled
  always @(posedge mclk) begin
    for (int i = 31; i > 0; i--) hist[i] = hist[i - 1];
    hist[0] = {phase_detect_in, reference_clock_in, signal_inputs};
    if (check_on) begin
      for (int c = 0; c < 4; c++) `CHECK("delayed output", exp_out(c), delayed_outputs[c])
      `CHECK("deskewed clock", exp_out(4), deskewed_clock_out)
    end
  end

  task automatic finish_test();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge mclk);
    #1;
    srst = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    `CHECK("outputs in reset", 5'h00, {deskewed_clock_out, delayed_outputs})
    `CHECK("drive enable in reset", 2'h2, {sda_drive_n, sda_out})
    srst = 1'b0;
    first_frame = 1'b1;
    for (int c = 0; c < 5; c++) exp_tap[c] = delay_prog_pkg::TAP_RESET;
  endtask

  // one frame, then a settled window of output comparisons
  task automatic frame(input logic [6:0] addr, input logic rd, input logic [7:0] data, input int nbits);
    logic       exp_ack;
    logic [4:0] t;
    exp_ack = !first_frame && !addr[6] && (addr[5:2] === address_select_pins) && !rd;
    i2c_controller_model_inst.send_frame(addr, rd, data, nbits, ack, nack);
    `CHECK("address ack", exp_ack, ack)
    `CHECK("data slot nack", 1'b1, nack)
    t = (data[4:0] > delay_prog_pkg::TAP_CONST_HIGH) ? delay_prog_pkg::TAP_CONST_LOW : data[4:0];
    if (exp_ack && nbits == 8 && data[7:5] <= delay_prog_pkg::CHAN_REFCLK) exp_tap[data[7:5]] = t;
    first_frame = 1'b0;
    repeat (40) @(posedge mclk);
    #1;
    check_on = 1'b1;
    repeat (12) @(posedge mclk);
    #1;
    check_on = 1'b0;
  endtask

  // main sequence
  initial begin
    srst = 1'b1;
    check_on = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    rnd_st = 32'h0000CC44;
    address_select_pins = 4'hA;
    do_reset();
    // dummy power-up frame aimed at this device is swallowed
    frame({1'b0, address_select_pins, 2'h0}, 1'b0, 8'h1B, 8);
    // every tap code over all five channels, random pins and low bits
    for (int v = 0; v < 32; v++) begin
      rnd_st = lfsr_next(rnd_st);
      address_select_pins = rnd_st[3:0];
      frame({1'b0, address_select_pins, rnd_st[5:4]}, 1'b0, {3'(v % 5), 5'(v)}, 8);
    end
    for (int c = 5; c < 8; c++) frame({1'b0, address_select_pins, 2'h1}, 1'b0, {3'(c), 5'h1B}, 8);
    frame({1'b1, address_select_pins, 2'h3}, 1'b0, 8'h1B, 8);
    frame({1'b0, address_select_pins ^ 4'h6, 2'h1}, 1'b0, 8'h3B, 8);
    frame({1'b0, address_select_pins, 2'h2}, 1'b1, 8'h5B, 8);
    frame({1'b0, address_select_pins, 2'h0}, 1'b0, 8'h7B, 7);
    repeat (12) begin
      rnd_st = lfsr_next(rnd_st);
      frame({1'b0, address_select_pins, rnd_st[9:8]}, 1'b0, rnd_st[17:10], 8);
    end
    // second reset mid-run: first frame ignored again, then one normal write
    do_reset();
    frame({1'b0, address_select_pins, 2'h0}, 1'b0, 8'h20, 8);
    frame({1'b0, address_select_pins, 2'h3}, 1'b0, 8'h58, 8);
    finish_test();
  end

  // hang guard, about three times the planned run of 54 frames
  initial begin
    #300000;
    n_mismatch++;
    finish_test();
  end
endmodule
`default_nettype wire
